// >>> src/cdb_check_consts.svh
/*
  byte positions, field layouts, sense codes and status values
  of the command block format checker, as `define macros.
  assumes: included by bare name from package and modules.
*/
`ifndef CDB_CHECK_CONSTS_SVH
`define CDB_CHECK_CONSTS_SVH

`define CDB_LEN6          4'h6
`define CDB_LEN10         4'hA
`define CDB_BYTE_OPCODE   4'h0
`define CDB_BYTE_LUN      4'h1
`define CDB_BYTE_ADDR0    4'h2
`define CDB_BYTE_RSVD10   4'h6
`define CDB_BYTE_LEN_HI   4'h7
`define CDB_BYTE_LEN_LO   4'h8
`define CDB_CTRL6         4'h5
`define CDB_CTRL10        4'h9
`define GROUP_SIX         3'h0
`define GROUP_TEN_A       3'h1
`define GROUP_TEN_B       3'h2
`define SUPPORTED_LUN     3'h0
`define CTRL_RSVD_MASK    8'h3C
`define CTRL_FLAG_BIT     1
`define CTRL_LINK_BIT     0
`define SENSE_ILLEGAL_REQ 4'h5
`define SENSE_NONE        4'h0
`define ASC_BAD_OPCODE    8'h20
`define ASC_BAD_LUN       8'h25
`define ASC_BAD_FIELD     8'h24
`define ASC_NONE          8'h00
`define ASCQ_ZERO         8'h00
`define STATUS_GOOD       8'h00
`define STATUS_CHECK      8'h02

`endif

// >>> src/cdb_check_pkg.sv
/*
  types of the command block format checker.
  assumes: cdb_check_consts.svh is on the include path.
*/
`include "cdb_check_consts.svh"

package cdb_check_pkg;

  typedef struct packed {
    logic [2:0]  group;
    logic [4:0]  command;
    logic [2:0]  lun;
    logic [4:0]  vendor;
    logic [31:0] block_addr;
    logic [15:0] length;
    logic [7:0]  control;
    logic        ten_byte;
  } cdb_fields_t;

  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sense_t;

  typedef enum logic [1:0] {
    ST_COLLECT,
    ST_CHECK,
    ST_REPORT
  } check_state_t;

  typedef struct packed {
    check_state_t state;
    logic [3:0]   count;
    logic [3:0]   expect_len;
    cdb_fields_t  fields;
    logic         execute;
    logic         done;
    logic [7:0]   status;
    sense_t       sense;
    logic         busy;
  } check_regs_t;

endpackage

// >>> src/cdb_byte_store.sv
/*
  one byte slot of the command block store.
  assumes: single clock, async active-low reset.
*/
`timescale 1ns/100ps

module cdb_byte_store #(
  parameter logic [3:0] SLOT = 4'h0
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_clear,
  input  wire logic       i_we,
  input  wire logic [3:0] i_index,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_byte
);

  logic [7:0] next_byte;

  always_comb begin
    next_byte = o_byte;
    if (i_clear) begin
      next_byte = 8'h00;
    end
    else if (i_we && (i_index == SLOT)) begin
      next_byte = i_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_byte <= 8'h00;
    end
    else begin
      o_byte <= next_byte;
    end
  end

endmodule // cdb_byte_store

// >>> src/cdb_format_checker.sv
/*
  command block format checker: collects a six or ten byte command
  block one byte per strobe, splits it into fields, checks format,
  reports status and sense or hands the fields on for execution.
  assumes: bytes arrive parity-checked; a parity error aborts the
  block through i_abort; i_nrst covers bus, device and power reset.
*/
`timescale 1ns/100ps
`include "cdb_check_consts.svh"

module cdb_format_checker (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_nrst,
  input  wire logic                       i_byte_valid,
  input  wire logic [7:0]                 i_byte,
  input  wire logic                       i_abort,
  input  wire logic                       i_opcode_ok,
  input  wire logic [1:0]                 i_vendor_ok_mask,
  output cdb_check_pkg::cdb_fields_t      o_fields,
  output logic                            o_execute,
  output logic                            o_done,
  output logic [7:0]                      o_status,
  output cdb_check_pkg::sense_t           o_sense,
  output logic                            o_busy
);
  import cdb_check_pkg::*;

  check_regs_t st;
  check_regs_t next_st;
  logic [7:0] cdb [0:9];
  logic       store_we;
  logic       store_clear;

  // one slot per byte position; the store is cleared between blocks
  for (genvar g = 0; g < 10; g++) begin : g_slot
    cdb_byte_store #(
      .SLOT (4'(g))
    ) u_slot (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_clear   (store_clear),
      .i_we      (store_we),
      .i_index   (st.count),
      .i_data    (i_byte),
      .o_byte    (cdb[g])
    );
  end

  assign store_we    = (st.state == ST_COLLECT) && i_byte_valid && !i_abort;
  assign store_clear = i_abort || (st.state == ST_REPORT);

  logic       err_op;
  logic       err_lun;
  logic       err_rsvd;
  logic       err_ctrl;
  logic [7:0] ctrl;
  logic [2:0] grp;

  always_comb begin
    grp      = cdb[`CDB_BYTE_OPCODE][7:5];
    ctrl     = st.expect_len == `CDB_LEN10 ? cdb[`CDB_CTRL10]
                                           : cdb[`CDB_CTRL6];
    err_op   = !i_opcode_ok;
    err_lun  = cdb[`CDB_BYTE_LUN][7:5] != `SUPPORTED_LUN;
    // only the standard-defined reserved fields are looked at
    err_rsvd = ((st.expect_len == `CDB_LEN10) &&
                (cdb[`CDB_BYTE_RSVD10] != 8'h00)) ||
               ((ctrl & `CTRL_RSVD_MASK) != 8'h00);
    err_ctrl = ctrl[`CTRL_FLAG_BIT] || ctrl[`CTRL_LINK_BIT] ||
               ((ctrl[7:6] & ~i_vendor_ok_mask) != 2'h0);
  end

  always_comb begin
    next_st         = st;
    next_st.execute = 1'b0;
    next_st.done    = 1'b0;
    case (st.state)
      ST_COLLECT: begin
        if (i_abort) begin
          next_st.count = 4'h0;
        end
        else if (i_byte_valid) begin
          if (st.count == 4'h0) begin
            case (i_byte[7:5])
              `GROUP_SIX:   next_st.expect_len = `CDB_LEN6;
              `GROUP_TEN_A,
              `GROUP_TEN_B: next_st.expect_len = `CDB_LEN10;
              // unknown group: six bytes, opcode check fails it
              default:      next_st.expect_len = `CDB_LEN6;
            endcase
          end
          next_st.count = st.count + 4'h1;
          if ((st.count != 4'h0) &&
              (st.count + 4'h1 == st.expect_len)) begin
            next_st.state = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        next_st.fields.group      = grp;
        next_st.fields.command    = cdb[`CDB_BYTE_OPCODE][4:0];
        next_st.fields.lun        = cdb[`CDB_BYTE_LUN][7:5];
        next_st.fields.vendor     = cdb[`CDB_BYTE_LUN][4:0];
        next_st.fields.control    = ctrl;
        next_st.fields.ten_byte   = st.expect_len == `CDB_LEN10;
        if (st.expect_len == `CDB_LEN10) begin
          next_st.fields.block_addr = {cdb[2], cdb[3], cdb[4], cdb[5]};
          next_st.fields.length     = {cdb[`CDB_BYTE_LEN_HI],
                                       cdb[`CDB_BYTE_LEN_LO]};
        end
        else begin
          next_st.fields.block_addr = {8'h00, cdb[2], cdb[3], cdb[4]};
          next_st.fields.length     = 16'h0000;
        end
        next_st.sense.ascq = `ASCQ_ZERO;
        next_st.sense.key  = `SENSE_ILLEGAL_REQ;
        next_st.status     = `STATUS_CHECK;
        // priority chain keeps only the first error found
        if (err_op) begin
          next_st.sense.asc = `ASC_BAD_OPCODE;
        end
        else if (err_lun) begin
          next_st.sense.asc = `ASC_BAD_LUN;
        end
        else if (err_rsvd) begin
          next_st.sense.asc = `ASC_BAD_FIELD;
        end
        else if (err_ctrl) begin
          next_st.sense.asc = `ASC_BAD_FIELD;
        end
        else begin
          next_st.sense   = '{`SENSE_NONE, `ASC_NONE, `ASCQ_ZERO};
          next_st.status  = `STATUS_GOOD;
          next_st.execute = 1'b1;
        end
        next_st.done  = 1'b1;
        next_st.state = ST_REPORT;
      end
      ST_REPORT: begin
        next_st.count = 4'h0;
        next_st.state = ST_COLLECT;
      end
      default: begin
        next_st.state = ST_COLLECT;
        next_st.count = 4'h0;
      end
    endcase
    // taken from the next state so busy rises with the check cycle
    next_st.busy = next_st.state != ST_COLLECT;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '{ST_COLLECT, 4'h0, `CDB_LEN6, '0, 1'b0, 1'b0,
              `STATUS_GOOD, '0, 1'b0};
    end
    else begin
      st <= next_st;
    end
  end

  assign o_fields  = st.fields;
  assign o_execute = st.execute;
  assign o_done    = st.done;
  assign o_status  = st.status;
  assign o_sense   = st.sense;
  assign o_busy    = st.busy;

  property p_execute_only_good;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_execute |-> (o_done && o_status == `STATUS_GOOD &&
                     o_sense.key == `SENSE_NONE);
  endproperty
  a_execute_only_good: assert property (p_execute_only_good)
    else $error("execute with error status");

  property p_opcode_first;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (st.state == ST_CHECK && err_op) |=>
        (o_sense.asc == `ASC_BAD_OPCODE && o_status == `STATUS_CHECK);
  endproperty
  a_opcode_first: assert property (p_opcode_first)
    else $error("bad opcode not reported");

  property p_lun;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (st.state == ST_CHECK && !err_op && err_lun) |=>
        (o_sense.asc == `ASC_BAD_LUN && !o_execute);
  endproperty
  a_lun: assert property (p_lun)
    else $error("bad unit not reported");

  property p_rsvd;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (st.state == ST_CHECK && !err_op && !err_lun && err_rsvd) |=>
        (o_sense.asc == `ASC_BAD_FIELD && o_sense.key == `SENSE_ILLEGAL_REQ);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved field not reported");

  property p_ctrl;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (st.state == ST_CHECK && !err_op && !err_lun && !err_rsvd
       && err_ctrl) |=> (o_sense.asc == `ASC_BAD_FIELD && !o_execute);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control byte error not reported");

  property p_check_status;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (o_done && !o_execute) |-> (o_status == `STATUS_CHECK &&
                                  o_sense.ascq == `ASCQ_ZERO);
  endproperty
  a_check_status: assert property (p_check_status)
    else $error("check condition status wrong");

  property p_ten_fields;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (st.state == ST_CHECK && st.expect_len == `CDB_LEN10) |=>
        (o_fields.length == {$past(cdb[7]), $past(cdb[8])} &&
         o_fields.block_addr[7:0] == $past(cdb[5]));
  endproperty
  a_ten_fields: assert property (p_ten_fields)
    else $error("ten byte fields wrong");

  property p_six_len;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (st.state == ST_COLLECT && st.count == 4'h0 && i_byte_valid &&
       !i_abort && i_byte[7:5] == `GROUP_SIX)
        ##1 (i_byte_valid && !i_abort) [*5] |-> ##2 o_done;
  endproperty
  a_six_len: assert property (p_six_len)
    else $error("six byte block not completed");

endmodule // cdb_format_checker

// >>> bench/initiator_model.sv
/*
  initiator model: sends command block bytes one per cycle.
  assumes: driven from the bench at falling edges of i_ref_clk.
*/
`timescale 1ns/100ps

module initiator_model (
  input  wire logic       i_ref_clk,
  output logic            o_byte_valid,
  output logic      [7:0] o_byte
);
  initial begin
    o_byte_valid = 1'b0;
    o_byte       = 8'h00;
  end

  // byte 0 of blk sits at the top; an idle cycle is inserted before gap
  // blk is sent unchanged; unit, flag and link bits are whatever the test puts in it
  task automatic send(input logic [79:0] blk, input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      if (k == gap) begin
        @(negedge i_ref_clk);
        o_byte_valid = 1'b0;
        o_byte       = ~o_byte;
      end
      @(negedge i_ref_clk);
      o_byte_valid = 1'b1;
      o_byte       = blk[79-8*k -: 8];
    end
    @(negedge i_ref_clk);
    o_byte_valid = 1'b0;
    // released data line must not show a stale byte
    o_byte       = ~o_byte;
  endtask
endmodule // initiator_model

// >>> bench/tb.sv
/*
  testbench of the command block format checker.
  assumes: initiator_model and the design files are compiled first.
*/
`timescale 1ns/100ps

module tb;
  import cdb_check_pkg::*;

  logic                 i_ref_clk = 1'b0;
  logic                 i_nrst    = 1'b0;
  logic                 byte_valid;
  logic [7:0]           byte_data;
  logic                 abort     = 1'b0;
  logic                 opcode_ok = 1'b1;
  logic [1:0]           vmask     = 2'b00;
  logic                 busy;
  cdb_fields_t          fields;
  logic                 execute;
  logic                 done;
  logic [7:0]           status;
  sense_t               sense;
  int                   failures  = 0;
  int                   tests_run = 0;
  int                   cycles    = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  initiator_model u_init (
    .i_ref_clk    (i_ref_clk),
    .o_byte_valid (byte_valid),
    .o_byte       (byte_data)
  );

  cdb_format_checker DUT (
    .i_ref_clk        (i_ref_clk),
    .i_nrst           (i_nrst),
    .i_byte_valid     (byte_valid),
    .i_byte           (byte_data),
    .i_abort          (abort),
    .i_opcode_ok      (opcode_ok),
    .i_vendor_ok_mask (vmask),
    .o_fields         (fields),
    .o_execute        (execute),
    .o_done           (done),
    .o_status         (status),
    .o_sense          (sense),
    .o_busy           (busy)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // 3000 cycles is several times the whole sequence
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  // one block, then wait a bounded time for the answer and compare it
  task automatic run(input logic [79:0] blk, input int n, input logic ok,
                     input logic [1:0] m, input logic [7:0] st,
                     input logic [7:0] asc);
    int w;
    w         = 0;
    opcode_ok = ok;
    vmask     = m;
    // six-byte blocks go back to back, ten-byte ones with a gap
    u_init.send(blk, n, (n == 6) ? n : 3);
    while (done !== 1'b1 && w < 10) begin
      @(negedge i_ref_clk);
      w++;
    end
    check("done", done, 1);
    check("busy", busy, 1);
    check("status", status, st);
    check("key", sense.key, (st == 8'h02) ? 4'h5 : 4'h0);
    check("asc", sense.asc, asc);
    check("ascq", sense.ascq, 0);
    check("execute", execute, st == 8'h00);
    @(negedge i_ref_clk);
    check("idle", busy, 0);
  endtask

  initial begin
    repeat (16) @(negedge i_ref_clk);
    check("reset status", status, 0);
    check("reset done", done, 0);
    check("reset busy", busy, 0);
    i_nrst = 1'b1;
    run(80'h0800_0000_0100_0000_0000, 6, 1, 2'b00, 8'h00, 8'h00);
    check("group", fields.group, 0);
    check("command", fields.command, 8);
    check("addr6", fields.block_addr, 32'h0000_0001);
    check("ten6", fields.ten_byte, 0);
    run(80'h2B1F_1234_5678_00AB_CD40, 10, 1, 2'b11, 8'h00, 8'h00);
    check("group10", fields.group, 1);
    check("command10", fields.command, 5'h0B);
    check("vendor", fields.vendor, 5'h1F);
    check("addr10", fields.block_addr, 32'h1234_5678);
    check("length", fields.length, 16'hABCD);
    check("control", fields.control, 8'h40);
    check("ten10", fields.ten_byte, 1);
    run(80'h4C00_0000_0000_0000_0000, 10, 1, 2'b00, 8'h00, 8'h00);
    // opcode error wins over unit and control errors
    run(80'h0F20_0000_0003_0000_0000, 6, 0, 2'b00, 8'h02, 8'h20);
    run(80'h6000_0000_0000_0000_0000, 6, 0, 2'b00, 8'h02, 8'h20);
    run(80'h0820_0000_0001_0000_0000, 6, 1, 2'b00, 8'h02, 8'h25);
    run(80'h2B00_0000_0000_0100_0000, 10, 1, 2'b00, 8'h02, 8'h24);
    for (int i = 0; i < 6; i++) begin
      logic [7:0] c;
      c = (i == 0) ? 8'h04 : (i == 1) ? 8'h20 : (i == 2) ? 8'h02 :
          (i == 3) ? 8'h01 : (i == 4) ? 8'h80 : 8'h40;
      run({40'h08_0000_0000, c, 32'h0000_0000}, 6, 1, 2'b00, 8'h02, 8'h24);
    end
    // a parity abort drops the partial block
    u_init.send(80'h2B00_0000_0000_0000_0000, 3, 9);
    abort = 1'b1;
    @(negedge i_ref_clk);
    abort = 1'b0;
    run(80'h0800_0000_0200_0000_0000, 6, 1, 2'b00, 8'h00, 8'h00);
    check("addr abort", fields.block_addr, 32'h0000_0002);
    report_and_stop();
  end
endmodule // tb
